//--- design/tdm_time_of_day.sv
// time-of-day unit: quarter-second counter, second and alarm events,
// register port and the shared interrupt request
// assumes a synchronous register master on clk and free time base pins
// time base pins are asynchronous and are synchronised before use
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module tdm_time_of_day
  import tdm_pkg::*;
#(
  parameter int unsigned DIV_SET0     = DIV_PS0,
  parameter int unsigned DIV_SET1     = DIV_PS1,
  parameter int unsigned DIV_SET2     = DIV_PS2,
  parameter int unsigned DIV_SET3     = DIV_PS3,
  parameter int unsigned DIV_SET4     = DIV_PS4,
  parameter int unsigned DIV_SET5     = DIV_PS5,
  parameter int unsigned DIV_SET6     = DIV_PS6,
  parameter int unsigned DIV_SET7     = DIV_PS7,
  parameter int unsigned WRITE_CYCLES = ALARM_WRITE_CYCLES
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire tdm_bus_req_t bus_req,
  output logic [DATA_W-1:0] rdata,
  input  wire logic         external_osc_clock,
  input  wire logic         low_power_1khz_osc,
  input  wire logic         internal_reference_clock,
  output logic              irq,
  output logic              clock_out
);

  // control register state
  logic            module_enable;
  tdm_src_t        time_base_select;
  logic            clock_output_enable;
  logic [2:0]      divider_setting;

  // status/control register state
  logic            quarter_tick_irq_enable;
  logic            whole_second_irq_enable;
  logic            alarm_irq_enable;
  logic            alarm_function_enable;
  logic            alarm_write_done;
  logic [7:0]      done_count;

  // alarm and counter
  logic [5:0]      alarm_value;
  logic [1:0]      alarm_quarter;
  logic [7:0]      quarter_second_counter;
  logic [7:0]      next_count;

  // decoded strobes
  logic            wr_control;
  logic            wr_status;
  logic            wr_alarm;
  logic            alarm_accept;
  logic            counter_restart;

  // tick and events
  logic [DIV_W-1:0] div_count;
  logic             tick;
  logic             src_level;
  logic             alarm_hit;
  logic [NUM_EVENTS-1:0] ev_set;
  logic [NUM_EVENTS-1:0] ev_clear;
  logic [NUM_EVENTS-1:0] ev_ie;
  logic [NUM_EVENTS-1:0] ev_flag;
  logic [NUM_EVENTS-1:0] ev_pending;

  // write address decode
  // unmapped indices decode to nothing and are dropped
  always_comb begin
    wr_control = 1'b0;
    wr_status  = 1'b0;
    wr_alarm   = 1'b0;
    if (bus_req.wr && bus_req.addr == ADDR_CONTROL) begin
      wr_control = 1'b1;
    end else if (bus_req.wr && bus_req.addr == ADDR_STATUS_CONTROL) begin
      wr_status = 1'b1;
    end else if (bus_req.wr && bus_req.addr == ADDR_ALARM_VALUE) begin
      wr_alarm = 1'b1;
    end
  end

  // restart is an action bit, it is never stored
  assign counter_restart = wr_control
                         & bus_req.wdata[CTL_RESTART_BIT];

  // a busy alarm port drops the write
  assign alarm_accept = wr_alarm & ~alarm_write_done;

  // module enable; clearing it holds counter and prescaler at zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      module_enable <= 1'b0;
    end else if (wr_control) begin
      module_enable <= bus_req.wdata[CTL_ENABLE_BIT];
    end
  end

  // time base select, external oscillator after reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      time_base_select <= tdm_src_t'(SEL_RESET);
    end else if (wr_control) begin
      time_base_select <=
        tdm_src_t'(bus_req.wdata[CTL_SEL_HI:CTL_SEL_LO]);
    end
  end

  // clock output enable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clock_output_enable <= 1'b0;
    end else if (wr_control) begin
      clock_output_enable <= bus_req.wdata[CTL_CLKOUT_BIT];
    end
  end

  // divider setting; changing it while enabled upsets the tick
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divider_setting <= PS_RESET;
    end else if (wr_control) begin
      divider_setting <= bus_req.wdata[CTL_PS_HI:CTL_PS_LO];
    end
  end

  // quarter tick interrupt enable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      quarter_tick_irq_enable <= 1'b0;
    end else if (wr_status) begin
      quarter_tick_irq_enable <= bus_req.wdata[ST_QUARTER_IE];
    end
  end

  // whole second interrupt enable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      whole_second_irq_enable <= 1'b0;
    end else if (wr_status) begin
      whole_second_irq_enable <= bus_req.wdata[ST_SECOND_IE];
    end
  end

  // alarm interrupt enable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_irq_enable <= 1'b0;
    end else if (wr_status) begin
      alarm_irq_enable <= bus_req.wdata[ST_ALARM_IE];
    end
  end

  // alarm compare enable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_function_enable <= 1'b0;
    end else if (wr_status) begin
      alarm_function_enable <= bus_req.wdata[ST_ALARM_EN];
    end
  end

  // alarm value, seconds part of the compare
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_value <= ALARM_RESET;
    end else if (alarm_accept) begin
      alarm_value <= bus_req.wdata[7:2];
    end
  end

  // quarter bits preloaded from the counter at write time
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_quarter <= 2'h0;
    end else if (alarm_accept) begin
      alarm_quarter <= quarter_second_counter[1:0];
    end
  end

  // write-done indication held for a fixed busy time
  // a second alarm write inside this window is dropped, not queued
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_write_done <= 1'b0;
      done_count       <= 8'h00;
    end else if (alarm_accept) begin
      alarm_write_done <= 1'b1;
      done_count       <= 8'(WRITE_CYCLES);
    end else if (done_count > 8'h01) begin
      done_count       <= done_count - 8'h01;
    end else begin
      alarm_write_done <= 1'b0;
      done_count       <= 8'h00;
    end
  end

  // divider count per setting
  always_comb begin
    case (divider_setting)
      3'h0:    div_count = DIV_W'(DIV_SET0);
      3'h1:    div_count = DIV_W'(DIV_SET1);
      3'h2:    div_count = DIV_W'(DIV_SET2);
      3'h3:    div_count = DIV_W'(DIV_SET3);
      3'h4:    div_count = DIV_W'(DIV_SET4);
      3'h5:    div_count = DIV_W'(DIV_SET5);
      3'h6:    div_count = DIV_W'(DIV_SET6);
      default: div_count = DIV_W'(DIV_SET7);
    endcase
  end

  // source select and 4 Hz tick; restart clears the prescaler too
  // only rising edges of the selected source are counted
  tdm_tick_gen #(
    .CNT_W      (DIV_W)
  ) u_tick (
    .clk        (clk),
    .reset_n    (reset_n),
    .src_raw    ({internal_reference_clock,
                  low_power_1khz_osc,
                  external_osc_clock}),
    .src_select (time_base_select),
    .run        (module_enable),
    .restart    (counter_restart),
    .div_count  (div_count),
    .tick       (tick),
    .src_level  (src_level)
  );

  // next count wraps from all ones to zero
  assign next_count = quarter_second_counter + 8'h01;

  // alarm compare against value and preloaded quarter bits
  // quarter bits make the hit fall on the intended quarter
  assign alarm_hit = alarm_function_enable & tick
                   & (next_count == {alarm_value, alarm_quarter});

  // quarter-second counter
  // a hit clears only the seconds part, so no quarter is lost
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      quarter_second_counter <= COUNTER_RESET;
    end else if (counter_restart || !module_enable) begin
      quarter_second_counter <= COUNTER_RESET;
    end else if (alarm_hit) begin
      quarter_second_counter <= {6'h00, next_count[1:0]};
    end else if (tick) begin
      quarter_second_counter <= next_count;
    end
  end

  // event sources and write-one clears
  always_comb begin
    ev_set[EV_QUARTER]   = tick;
    ev_set[EV_SECOND]    = tick & (next_count[1:0] == 2'h0);
    ev_set[EV_ALARM]     = alarm_hit;
    ev_clear[EV_QUARTER] = wr_status & bus_req.wdata[ST_QUARTER_FLAG];
    ev_clear[EV_SECOND]  = wr_status & bus_req.wdata[ST_SECOND_FLAG];
    ev_clear[EV_ALARM]   = wr_status & bus_req.wdata[ST_ALARM_FLAG];
    ev_ie[EV_QUARTER]    = quarter_tick_irq_enable;
    ev_ie[EV_SECOND]     = whole_second_irq_enable;
    ev_ie[EV_ALARM]      = alarm_irq_enable;
  end

  // one sticky flag per event
  for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_flag
    tdm_event_flag u_flag (
      .clk        (clk),
      .reset_n    (reset_n),
      .set        (ev_set[i]),
      .clear      (ev_clear[i]),
      .irq_enable (ev_ie[i]),
      .flag       (ev_flag[i]),
      .pending    (ev_pending[i])
    );
  end

  // shared level request; a flag left set with its enable on keeps it high
  // registered, so it rises one cycle after the flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |ev_pending;
    end
  end

  // clock output follows the selected source when enabled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clock_out <= 1'b0;
    end else begin
      clock_out <= src_level & clock_output_enable & module_enable;
    end
  end

  // read data, valid only in the cycle after the read strobe
  // returns zero otherwise so a stale value is never seen
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (bus_req.rd && bus_req.addr == ADDR_CONTROL) begin
      rdata <= {module_enable, time_base_select, 1'b0,
                clock_output_enable, divider_setting};
    end else if (bus_req.rd && bus_req.addr == ADDR_STATUS_CONTROL) begin
      rdata <= {ev_flag[EV_QUARTER], ev_flag[EV_SECOND],
                ev_flag[EV_ALARM], quarter_tick_irq_enable,
                whole_second_irq_enable, alarm_irq_enable,
                alarm_function_enable, alarm_write_done};
    end else if (bus_req.rd && bus_req.addr == ADDR_ALARM_VALUE) begin
      rdata <= {alarm_value, alarm_quarter};
    end else if (bus_req.rd && bus_req.addr == ADDR_COUNTER) begin
      rdata <= quarter_second_counter;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

//--- design/tdm_pkg.sv
// constants, register map and carrier types of the time-of-day unit
// assumes a 10 MHz system clock and 8-bit register data
package tdm_pkg;

  // system clock
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 100;

  // register port geometry
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // register indices
  localparam logic [2:0] ADDR_CONTROL        = 3'h0;
  localparam logic [2:0] ADDR_STATUS_CONTROL = 3'h1;
  localparam logic [2:0] ADDR_ALARM_VALUE    = 3'h2;
  localparam logic [2:0] ADDR_COUNTER        = 3'h3;

  // timekeeper_control fields
  localparam int unsigned CTL_ENABLE_BIT  = 7;
  localparam int unsigned CTL_SEL_HI      = 6;
  localparam int unsigned CTL_SEL_LO      = 5;
  localparam int unsigned CTL_RESTART_BIT = 4;
  localparam int unsigned CTL_CLKOUT_BIT  = 3;
  localparam int unsigned CTL_PS_HI       = 2;
  localparam int unsigned CTL_PS_LO       = 0;

  // timekeeper_status_control fields
  localparam int unsigned ST_QUARTER_FLAG = 7;
  localparam int unsigned ST_SECOND_FLAG  = 6;
  localparam int unsigned ST_ALARM_FLAG   = 5;
  localparam int unsigned ST_QUARTER_IE   = 4;
  localparam int unsigned ST_SECOND_IE    = 3;
  localparam int unsigned ST_ALARM_IE     = 2;
  localparam int unsigned ST_ALARM_EN     = 1;
  localparam int unsigned ST_WRITE_DONE   = 0;

  // reset values
  localparam logic [1:0] SEL_RESET     = 2'h0;
  localparam logic [2:0] PS_RESET      = 3'h1;
  localparam logic [5:0] ALARM_RESET   = 6'h00;
  localparam logic [7:0] COUNTER_RESET = 8'h00;

  // event slots of the shared interrupt
  localparam int unsigned EV_QUARTER = 0;
  localparam int unsigned EV_SECOND  = 1;
  localparam int unsigned EV_ALARM   = 2;
  localparam int unsigned NUM_EVENTS = 3;

  // prescaler: source edges per 4 Hz tick for each divider setting
  localparam int unsigned TICK_HZ = 4;
  localparam int unsigned DIV_W   = 24;
  localparam int unsigned DIV_PS0 = 1_000 / TICK_HZ;
  localparam int unsigned DIV_PS1 = 32_768 / TICK_HZ;
  localparam int unsigned DIV_PS2 = 32_000 / TICK_HZ;
  localparam int unsigned DIV_PS3 = 38_400 / TICK_HZ;
  localparam int unsigned DIV_PS4 = 4_915_200 / TICK_HZ;
  localparam int unsigned DIV_PS5 = 4_000_000 / TICK_HZ;
  localparam int unsigned DIV_PS6 = 8_000_000 / TICK_HZ;
  localparam int unsigned DIV_PS7 = 16_000_000 / TICK_HZ;

  // busy time after an alarm value write
  localparam int unsigned ALARM_WRITE_NS     = 400;
  localparam int unsigned ALARM_WRITE_CYCLES =
    (ALARM_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // time base selection codes
  typedef enum logic [1:0] {
    TDM_SRC_EXT_OSC = 2'b00,
    TDM_SRC_LOW_PWR = 2'b01,
    TDM_SRC_IRC     = 2'b10,
    TDM_SRC_NONE    = 2'b11
  } tdm_src_t;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } tdm_bus_req_t;

endpackage

//--- design/tdm_event_flag.sv
// one sticky event flag with its interrupt enable
// assumes set and clear are one-cycle pulses on clk
`timescale 1ns/1ps
`default_nettype none
module tdm_event_flag
  import tdm_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic set,
  input  wire logic clear,
  input  wire logic irq_enable,
  output logic      flag,
  output logic      pending
);

  // set beats a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end

  // flag gated by its enable
  assign pending = flag & irq_enable;

endmodule
`default_nettype wire

//--- design/tdm_tick_gen.sv
// time base selection and 4 Hz tick prescaler
// assumes the source clocks are asynchronous and slower than clk / 2
`timescale 1ns/1ps
`default_nettype none
module tdm_tick_gen
  import tdm_pkg::*;
#(
  parameter int unsigned CNT_W = DIV_W
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [2:0]       src_raw,
  input  wire tdm_src_t         src_select,
  input  wire logic             run,
  input  wire logic             restart,
  input  wire logic [CNT_W-1:0] div_count,
  output logic                  tick,
  output logic                  src_level
);

  logic [2:0]       sync_1;
  logic [2:0]       sync_2;
  logic             selected;
  logic             edge_seen;
  logic [CNT_W-1:0] edge_count;

  // two-stage synchroniser per source
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        sync_1[i] <= 1'b0;
        sync_2[i] <= 1'b0;
      end else begin
        sync_1[i] <= src_raw[i];
        sync_2[i] <= sync_1[i];
      end
    end
  end

  // source mux on synchronised levels
  always_comb begin
    case (src_select)
      TDM_SRC_EXT_OSC: selected = sync_2[0];
      TDM_SRC_LOW_PWR: selected = sync_2[1];
      TDM_SRC_IRC:     selected = sync_2[2];
      default:         selected = 1'b0;
    endcase
  end

  assign edge_seen = selected & ~src_level;

  // previous level, also used for the clock output
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      src_level <= 1'b0;
    end else begin
      src_level <= selected;
    end
  end

  // divide rising edges down to one tick pulse
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      edge_count <= '0;
      tick       <= 1'b0;
    end else if (!run || restart) begin
      edge_count <= '0;
      tick       <= 1'b0;
    end else if (edge_seen && edge_count >= div_count - 1'b1) begin
      edge_count <= '0;
      tick       <= 1'b1;
    end else if (edge_seen) begin
      edge_count <= edge_count + 1'b1;
      tick       <= 1'b0;
    end else begin
      tick       <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- verification/tdm_time_of_day_monitor.sv
// checker for the time-of-day unit, bound to its top module
// assumes read data one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module tdm_monitor
  import tdm_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire tdm_bus_req_t      bus_req,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              external_osc_clock,
  input wire logic              low_power_1khz_osc,
  input wire logic              internal_reference_clock,
  input wire logic              irq,
  input wire logic              clock_out
);
  logic       ctl_wr, ctl_rd, st_wr, st_rd, al_wr;
  logic [7:0] ctl_sh;
  logic [2:0] ie_sh;
  logic [1:0] since_st;

  // decoded strobes
  assign ctl_wr = bus_req.wr && bus_req.addr == ADDR_CONTROL;
  assign ctl_rd = bus_req.rd && bus_req.addr == ADDR_CONTROL;
  assign st_wr  = bus_req.wr && bus_req.addr == ADDR_STATUS_CONTROL;
  assign st_rd  = bus_req.rd && bus_req.addr == ADDR_STATUS_CONTROL;
  assign al_wr  = bus_req.wr && bus_req.addr == ADDR_ALARM_VALUE;

  // shadows of the written control byte and interrupt enables
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_sh <= 8'h01;
      ie_sh  <= 3'h0;
    end else begin
      if (ctl_wr) begin
        ctl_sh <= bus_req.wdata;
      end
      if (st_wr) begin
        ie_sh <= bus_req.wdata[4:2];
      end
    end
  end

  // cycles since the last status write, saturating at 3
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      since_st <= 2'h3;
    end else if (st_wr) begin
      since_st <= 2'h0;
    end else if (since_st != 2'h3) begin
      since_st <= since_st + 2'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_read_data_idle: assert property (
    rdata != 8'h00 |-> $past(bus_req.rd)) else $error("rdata without read");
  a_unmapped_zero: assert property (
    bus_req.rd && bus_req.addr > 3'h3 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_control_readback: assert property (
    ctl_wr ##2 ctl_rd |=> rdata == ($past(bus_req.wdata, 3) & 8'hEF))
    else $error("control readback wrong");
  a_enables_readback: assert property (
    st_wr ##2 st_rd |=> rdata[4:1] == $past(bus_req.wdata[4:1], 3))
    else $error("status enables readback wrong");
  a_write_done_busy: assert property (
    al_wr ##2 st_rd |=> rdata[ST_WRITE_DONE])
    else $error("write done not shown after alarm write");
  a_irq_needs_enable: assert property (
    $rose(irq) |-> ie_sh != 3'h0) else $error("irq with no enable");
  a_irq_fall_cause: assert property (
    $fell(irq) |-> since_st != 2'h3) else $error("irq fell with no write");
  a_clock_out_gated: assert property (
    !(ctl_sh[7] && ctl_sh[3]) [*6] |-> !clock_out)
    else $error("clock out while gated off");

  c_irq_rise: cover property ($rose(irq));
  c_alarm_write: cover property (al_wr ##2 st_rd);
  c_clock_out: cover property ($rose(clock_out));
endmodule

bind tdm_time_of_day tdm_monitor u_mon (
  .clk                     (clk),
  .reset_n                 (reset_n),
  .bus_req                 (bus_req),
  .rdata                   (rdata),
  .external_osc_clock      (external_osc_clock),
  .low_power_1khz_osc      (low_power_1khz_osc),
  .internal_reference_clock(internal_reference_clock),
  .irq                     (irq),
  .clock_out               (clock_out)
);
`default_nettype wire

//--- verification/tdm_time_of_day_bench.sv
// self-checking bench for the time-of-day unit
// assumes a 10 MHz clock and the one-cycle register port
`timescale 1ns/1ps
`default_nettype none
module tdm_time_of_day_bench import tdm_pkg::*;;
  logic         clk, reset_n, irq, clock_out, irq_d;
  tdm_bus_req_t bus_req;
  logic [7:0]   rdata, d;
  logic [2:0]   src;
  int           n_fail, comparisons, rises, co_hi, cur, r0;

  // only divider setting 001 is used, shortened to two edges per tick
  tdm_time_of_day #(
    .DIV_SET1    (2),
    .WRITE_CYCLES(8)
  ) dut (
    .clk                     (clk),
    .reset_n                 (reset_n),
    .bus_req                 (bus_req),
    .rdata                   (rdata),
    .external_osc_clock      (src[0]),
    .low_power_1khz_osc      (src[1]),
    .internal_reference_clock(src[2]),
    .irq                     (irq),
    .clock_out               (clock_out)
  );

  // clock and time-zero values
  initial begin
    clk = 1'b0; reset_n = 1'b0; bus_req = '0; src = 3'h0; irq_d = 1'b0;
    n_fail = 0; comparisons = 0; rises = 0; co_hi = 0; cur = 0;
  end
  always #50 clk = ~clk;

  // irq rising edges and clock output activity
  always @(posedge clk) begin
    irq_d <= irq;
    if (irq && !irq_d) begin
      rises <= rises + 1;
    end
    if (clock_out) begin
      co_hi <= co_hi + 1;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask

  // read data stand in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1;
    v = rdata;
  endtask

  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(v, e);
  endtask

  task automatic ci(input logic e);
    repeat (3) @(posedge clk);
    chk({7'h00, irq}, {7'h00, e});
  endtask

  // n ticks of the selected source, two rising edges each
  task automatic tk(input int n);
    repeat (2 * n) begin
      @(posedge clk);
      src[cur] <= 1'b1;
      repeat (3) @(posedge clk);
      src[cur] <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask

  task automatic end_of_test;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog well beyond the fewer than a thousand cycles the tests need
  initial begin
    #(CLK_PERIOD_NS * 40000);
    n_fail++;
    end_of_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    // reset values and an unmapped index
    rc(ADDR_CONTROL, 8'h01);
    rc(ADDR_STATUS_CONTROL, 8'h00);
    rc(ADDR_ALARM_VALUE, 8'h00);
    rc(ADDR_COUNTER, 8'h00);
    rc(3'h5, 8'h00);
    // every time base counts one tick after a restart
    for (cur = 0; cur < 3; cur++) begin
      wr(ADDR_CONTROL, {1'b1, cur[1:0], 5'b10001});
      tk(1);
      rc(ADDR_COUNTER, 8'h01);
    end
    cur = 0;
    // select 11 has no source: no tick, restart reads back as zero
    wr(ADDR_CONTROL, 8'hF1);
    rc(ADDR_CONTROL, 8'hE1);
    tk(1);
    rc(ADDR_COUNTER, 8'h00);
    rc(ADDR_STATUS_CONTROL, 8'h80);
    // one-second flag, its request and its clearing
    wr(ADDR_CONTROL, 8'h91);
    wr(ADDR_STATUS_CONTROL, 8'hE8);
    rc(ADDR_STATUS_CONTROL, 8'h08);
    tk(3);
    ci(1'b0);
    tk(1);
    ci(1'b1);
    rc(ADDR_STATUS_CONTROL, 8'hC8);
    wr(ADDR_STATUS_CONTROL, 8'h48);
    ci(1'b0);
    tk(4);
    ci(1'b1);
    // both events at a whole second give a single request
    wr(ADDR_STATUS_CONTROL, 8'hF8);
    tk(3);
    wr(ADDR_STATUS_CONTROL, 8'hF8);
    ci(1'b0);
    r0 = rises;
    tk(1);
    chk(8'(rises - r0), 8'h01);
    rc(ADDR_STATUS_CONTROL, 8'hD8);
    wr(ADDR_STATUS_CONTROL, 8'h98);
    ci(1'b1);
    wr(ADDR_STATUS_CONTROL, 8'h58);
    ci(1'b0);
    // alarm one second ahead, low bits keep counting
    wr(ADDR_CONTROL, 8'h91);
    tk(1);
    wr(ADDR_STATUS_CONTROL, 8'hE0);
    wr(ADDR_ALARM_VALUE, 8'h04);
    rc(ADDR_ALARM_VALUE, 8'h05);
    wr(ADDR_STATUS_CONTROL, 8'h06);
    tk(4);
    rc(ADDR_COUNTER, 8'h01);
    ci(1'b1);
    wr(ADDR_STATUS_CONTROL, 8'h26);
    ci(1'b0);
    tk(4);
    ci(1'b1);
    wr(ADDR_STATUS_CONTROL, 8'h22);
    tk(4);
    rc(ADDR_COUNTER, 8'h01);
    rc(ADDR_STATUS_CONTROL, 8'hE2);
    ci(1'b0);
    wr(ADDR_STATUS_CONTROL, 8'hE0);
    tk(4);
    rc(ADDR_COUNTER, 8'h05);
    // second alarm write during the busy time is dropped
    wr(ADDR_ALARM_VALUE, 8'h10);
    rd(ADDR_STATUS_CONTROL, d);
    chk(d & 8'h01, 8'h01);
    wr(ADDR_ALARM_VALUE, 8'h20);
    rd(ADDR_ALARM_VALUE, d);
    chk(d & 8'hFC, 8'h10);
    repeat (10) @(posedge clk);
    rc(ADDR_STATUS_CONTROL, 8'hC0);
    wr(ADDR_ALARM_VALUE, 8'h20);
    rd(ADDR_ALARM_VALUE, d);
    chk(d & 8'hFC, 8'h20);
    // clock output only when enabled, counter held at zero when disabled
    chk(8'(co_hi), 8'h00);
    wr(ADDR_CONTROL, 8'h89);
    rc(ADDR_CONTROL, 8'h89);
    tk(1);
    chk(8'(co_hi != 0), 8'h01);
    wr(ADDR_CONTROL, 8'h01);
    tk(1);
    rc(ADDR_COUNTER, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
